// file: hdl/irq_status_pkg.sv
// Constants shared by the pin event and interrupt status logic.
// Assumes one 50 MHz core clock and a register port fed by the serial engine.
//
// Summary of operation
// - Configured edge on a pin sets its event bit, regardless of mask.
// - Configured edge on an enabled pin sets its interrupt source bit.
// - Writing one to a source bit clears it and its event bit.
// - Writing one to an event bit clears it and its source bit.
// - Interrupt line released high once all source bits are clear.
// - Changing a pin's edge selection clears that pin's event bit.
// - Source registers: high bank at 0x18, low bank at 0x19, eight bits.
// - Event registers: high bank 0x1a, low bank 0x1b; all reset zero.
// - Low bank holds pins 0 to 7, high bank pins 8 to 15.
// - Each pin has a two-bit edge selection field.
package irq_status_pkg;

	localparam int unsigned PIN_COUNT  = 16;
	localparam int unsigned BANK_WIDTH = 8;
	localparam int unsigned SEL_WIDTH  = 2;
	localparam int unsigned ADDR_WIDTH = 8;

	// Register byte addresses
	localparam logic [7:0] IRQ_SOURCE_HIGH_OFS = 8'h18;
	localparam logic [7:0] IRQ_SOURCE_LOW_OFS  = 8'h19;
	localparam logic [7:0] EDGE_EVENT_HIGH_OFS = 8'h1a;
	localparam logic [7:0] EDGE_EVENT_LOW_OFS  = 8'h1b;

	// Reset value of all four status registers
	localparam logic [7:0]  STATUS_RESET   = 8'h00;
	localparam logic [15:0] PIN_VEC_RESET  = 16'h0000;
	localparam logic [31:0] SEL_VEC_RESET  = 32'h0000_0000;

	// Bank bit positions: low bank pins 0..7, high bank pins 8..15
	localparam int unsigned LOW_BANK_LSB  = 0;
	localparam int unsigned HIGH_BANK_LSB = 8;

	// Edges after reset before the pin history holds real samples
	localparam int unsigned SYNC_PRIME_DEPTH = 3;

	// Edge selection codes, one two-bit field per pin
	localparam logic [1:0] EDGE_NONE    = 2'h0;
	localparam logic [1:0] EDGE_RISING  = 2'h1;
	localparam logic [1:0] EDGE_FALLING = 2'h2;
	localparam logic [1:0] EDGE_BOTH    = 2'h3;

	// Register selected by the access port
	typedef enum logic [3:0] {
		SEL_SRC_HIGH = 4'b0001,
		SEL_SRC_LOW  = 4'b0010,
		SEL_EVT_HIGH = 4'b0100,
		SEL_EVT_LOW  = 4'b1000
	} reg_sel_type;

endpackage : irq_status_pkg

// file: hdl/pin_edge_detect.sv
// Pin synchroniser and per-pin edge detector.
// Assumes pins are asynchronous and edge selection comes from core logic.
`timescale 1ns/1ps

module pin_edge_detect
	import irq_status_pkg::*;
(
	input  wire logic                         ref_clk,
	input  wire logic                         resetn,
	input  wire logic [PIN_COUNT-1:0]         pin_in,
	input  wire logic [PIN_COUNT*SEL_WIDTH-1:0] edge_select,
	output logic      [PIN_COUNT-1:0]         edge_hit
);

	logic [PIN_COUNT-1:0] meta_ff;
	logic [PIN_COUNT-1:0] sync_ff;
	logic [PIN_COUNT-1:0] prev_ff;
	logic [PIN_COUNT-1:0] nxt_meta;
	logic [PIN_COUNT-1:0] nxt_sync;
	logic [PIN_COUNT-1:0] nxt_prev;
	logic [SYNC_PRIME_DEPTH-1:0] prime_ff;
	logic [SYNC_PRIME_DEPTH-1:0] nxt_prime;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchroniser, then one stage of history for edge compare.
	// History resets low, so a pin held high across reset would look like
	// a rising edge; edges are ignored until the history is primed.
	always_comb
	begin
		nxt_meta  = pin_in;
		nxt_sync  = meta_ff;
		nxt_prev  = sync_ff;
		nxt_prime = {prime_ff[SYNC_PRIME_DEPTH-2:0], 1'b1};
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_ff <= PIN_VEC_RESET;
			sync_ff <= PIN_VEC_RESET;
			prev_ff <= PIN_VEC_RESET;
			prime_ff <= {SYNC_PRIME_DEPTH{1'b0}};
		end
		else
		begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			prev_ff <= nxt_prev;
			prime_ff <= nxt_prime;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Edge match against each pin's own selection field
	always_comb
	begin
		for (int i = 0; i < PIN_COUNT; i++)
		begin
			unique case (edge_select[i*SEL_WIDTH +: SEL_WIDTH])
				EDGE_NONE:    edge_hit[i] = 1'b0;
				EDGE_RISING:  edge_hit[i] = sync_ff[i] & ~prev_ff[i];
				EDGE_FALLING: edge_hit[i] = ~sync_ff[i] & prev_ff[i];
				EDGE_BOTH:    edge_hit[i] = sync_ff[i] ^ prev_ff[i];
			endcase
			edge_hit[i] = edge_hit[i] & prime_ff[SYNC_PRIME_DEPTH-1];
		end
	end

endmodule : pin_edge_detect

// file: hdl/select_change_detect.sv
// Flags pins whose edge selection field changed since the last clock.
// Assumes edge selection is held in core-clock registers elsewhere.
`timescale 1ns/1ps

module select_change_detect
	import irq_status_pkg::*;
(
	input  wire logic                           ref_clk,
	input  wire logic                           resetn,
	input  wire logic [PIN_COUNT*SEL_WIDTH-1:0] edge_select,
	output logic      [PIN_COUNT-1:0]           select_changed
);

	logic [PIN_COUNT*SEL_WIDTH-1:0] last_sel_ff;
	logic [PIN_COUNT*SEL_WIDTH-1:0] nxt_last_sel;

	////////////////////////////////////////////////////////////////////////
	// Keep last selection; reset value matches the selection reset value
	always_comb
	begin
		nxt_last_sel = edge_select;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			last_sel_ff <= SEL_VEC_RESET;
		else
			last_sel_ff <= nxt_last_sel;
	end

	// Any bit of a pin's field differing counts as a change
	always_comb
	begin
		for (int i = 0; i < PIN_COUNT; i++)
			select_changed[i] = |(edge_select[i*SEL_WIDTH +: SEL_WIDTH]
				^ last_sel_ff[i*SEL_WIDTH +: SEL_WIDTH]);
	end

endmodule : select_change_detect

// file: hdl/gpio_event_interrupt_status.sv
// Event capture and interrupt status for a sixteen-pin expander.
// Assumes the serial engine presents byte-wide single-cycle register
// accesses, and the edge selection and enable mask registers live outside.
`timescale 1ns/1ps

module gpio_event_interrupt_status
	import irq_status_pkg::*;
(
	input  wire logic                           ref_clk,
	input  wire logic                           resetn,
	input  wire logic [PIN_COUNT-1:0]           pin_in,
	input  wire logic [PIN_COUNT*SEL_WIDTH-1:0] edge_select_reg,
	input  wire logic [PIN_COUNT-1:0]           irq_enable_mask_reg,
	input  wire logic [ADDR_WIDTH-1:0]          reg_addr,
	input  wire logic                           reg_wr,
	input  wire logic [BANK_WIDTH-1:0]          reg_wdata,
	input  wire logic                           reg_rd,
	output logic      [BANK_WIDTH-1:0]          reg_rdata,
	output logic                                reg_rvalid,
	output logic                                irq_out_n_o,
	output logic                                irq_out_n_oe
);

	////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Decode a byte address onto a one-hot register select
	function automatic reg_sel_type decode_addr(
		input logic [ADDR_WIDTH-1:0] addr
	);
		reg_sel_type sel;
		sel = SEL_SRC_HIGH;
		unique case (addr)
			IRQ_SOURCE_HIGH_OFS: sel = SEL_SRC_HIGH;
			IRQ_SOURCE_LOW_OFS:  sel = SEL_SRC_LOW;
			EDGE_EVENT_HIGH_OFS: sel = SEL_EVT_HIGH;
			EDGE_EVENT_LOW_OFS:  sel = SEL_EVT_LOW;
			default:             sel = SEL_SRC_HIGH;
		endcase
		return sel;
	endfunction : decode_addr

	// True when the address hits one of the four status registers
	function automatic logic addr_mapped(
		input logic [ADDR_WIDTH-1:0] addr
	);
		return (addr == IRQ_SOURCE_HIGH_OFS) ||
			(addr == IRQ_SOURCE_LOW_OFS) ||
			(addr == EDGE_EVENT_HIGH_OFS) ||
			(addr == EDGE_EVENT_LOW_OFS);
	endfunction : addr_mapped

	// Place a bank-wide byte onto the sixteen-pin vector
	function automatic logic [PIN_COUNT-1:0] to_pins(
		input logic [BANK_WIDTH-1:0] data,
		input logic                  high_bank
	);
		logic [PIN_COUNT-1:0] v;
		v = PIN_VEC_RESET;
		if (high_bank)
			v[HIGH_BANK_LSB +: BANK_WIDTH] = data;
		else
			v[LOW_BANK_LSB +: BANK_WIDTH] = data;
		return v;
	endfunction : to_pins

	// Sticky bit update in which a new event outranks a clear
	function automatic logic [PIN_COUNT-1:0] sticky(
		input logic [PIN_COUNT-1:0] cur,
		input logic [PIN_COUNT-1:0] set,
		input logic [PIN_COUNT-1:0] clr
	);
		return set | (cur & ~clr);
	endfunction : sticky

	////////////////////////////////////////////////////////////////////////
	// Pin edges and edge selection changes

	logic [PIN_COUNT-1:0] edge_hit;
	logic [PIN_COUNT-1:0] select_changed;

	// Synchronised edge match per pin
	pin_edge_detect u_pin_edge_detect (
		.ref_clk     (ref_clk),
		.resetn      (resetn),
		.pin_in      (pin_in),
		.edge_select (edge_select_reg),
		.edge_hit    (edge_hit)
	);

	// Software writes to the selection field show up here
	select_change_detect u_select_change_detect (
		.ref_clk        (ref_clk),
		.resetn         (resetn),
		.edge_select    (edge_select_reg),
		.select_changed (select_changed)
	);

	////////////////////////////////////////////////////////////////////////
	// Write decode into per-pin clear strobes

	reg_sel_type          wr_sel;
	logic                 wr_hit;
	logic [PIN_COUNT-1:0] w1c_source;
	logic [PIN_COUNT-1:0] w1c_event;

	// Writes to unmapped addresses are dropped without effect
	always_comb
	begin
		wr_sel     = decode_addr(reg_addr);
		wr_hit     = reg_wr && addr_mapped(reg_addr);
		w1c_source = PIN_VEC_RESET;
		w1c_event  = PIN_VEC_RESET;
		if (wr_hit)
		begin
			unique case (wr_sel)
				SEL_SRC_HIGH: w1c_source = to_pins(reg_wdata, 1'b1);
				SEL_SRC_LOW:  w1c_source = to_pins(reg_wdata, 1'b0);
				SEL_EVT_HIGH: w1c_event  = to_pins(reg_wdata, 1'b1);
				SEL_EVT_LOW:  w1c_event  = to_pins(reg_wdata, 1'b0);
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status bits: event and interrupt source, both banks

	logic [PIN_COUNT-1:0] event_ff;
	logic [PIN_COUNT-1:0] source_ff;
	logic [PIN_COUNT-1:0] nxt_event;
	logic [PIN_COUNT-1:0] nxt_source;
	logic [PIN_COUNT-1:0] set_event;
	logic [PIN_COUNT-1:0] set_source;
	logic [PIN_COUNT-1:0] clr_event;
	logic [PIN_COUNT-1:0] clr_source;

	// Clearing either register of a pin clears both bits of that pin, so
	// software sees a source flag without its event flag only after a selection change. A selection
	// change wipes only the event bit; a pending interrupt stays pending.
	always_comb
	begin
		set_event  = edge_hit;
		set_source = edge_hit & irq_enable_mask_reg;
		clr_source = w1c_source | w1c_event;
		clr_event  = w1c_source | w1c_event | select_changed;
		nxt_event  = sticky(event_ff, set_event, clr_event);
		nxt_source = sticky(source_ff, set_source, clr_source);
	end

	// Both registers come up clear
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			event_ff  <= PIN_VEC_RESET;
			source_ff <= PIN_VEC_RESET;
		end
		else
		begin
			event_ff  <= nxt_event;
			source_ff <= nxt_source;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Open-drain interrupt line

	logic irq_oe_ff;
	logic nxt_irq_oe;

	// Built from next state so the line follows the source bits with no
	// extra cycle of lag; still leaves the block straight from a flop.
	always_comb
	begin
		nxt_irq_oe = |nxt_source;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			irq_oe_ff <= 1'b0;
		else
			irq_oe_ff <= nxt_irq_oe;
	end

	// Open drain: the driven level is always low, only enable moves
	logic irq_level_ff;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			irq_level_ff <= 1'b0;
		else
			irq_level_ff <= 1'b0;
	end

	assign irq_out_n_o  = irq_level_ff;
	assign irq_out_n_oe = irq_oe_ff;

	////////////////////////////////////////////////////////////////////////
	// Read path

	logic [BANK_WIDTH-1:0] rdata_ff;
	logic                  rvalid_ff;
	logic [BANK_WIDTH-1:0] nxt_rdata;
	logic                  nxt_rvalid;
	reg_sel_type           rd_sel;

	// Registered answer one cycle after the strobe; unmapped reads give
	// zero. Reads have no side effect, and the value shown is the one held
	// before any write in the same cycle takes effect.
	always_comb
	begin
		rd_sel     = decode_addr(reg_addr);
		nxt_rvalid = reg_rd;
		nxt_rdata  = STATUS_RESET;
		if (reg_rd && addr_mapped(reg_addr))
		begin
			unique case (rd_sel)
				SEL_SRC_HIGH:
					nxt_rdata = source_ff[HIGH_BANK_LSB +: BANK_WIDTH];
				SEL_SRC_LOW:
					nxt_rdata = source_ff[LOW_BANK_LSB +: BANK_WIDTH];
				SEL_EVT_HIGH:
					nxt_rdata = event_ff[HIGH_BANK_LSB +: BANK_WIDTH];
				SEL_EVT_LOW:
					nxt_rdata = event_ff[LOW_BANK_LSB +: BANK_WIDTH];
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_ff  <= STATUS_RESET;
			rvalid_ff <= 1'b0;
		end
		else
		begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	assign reg_rdata  = rdata_ff;
	assign reg_rvalid = rvalid_ff;

endmodule : gpio_event_interrupt_status

// file: tb/irq_status_monitor.sv
// Port checker for the event and interrupt status block.
// Assumes it is bound to the block's top module, one clock domain.
`timescale 1ns/1ps

module irq_status_monitor
	import irq_status_pkg::*;
(
	input wire logic                  ref_clk,
	input wire logic                  resetn,
	input wire logic [PIN_COUNT-1:0]  pin_in,
	input wire logic [ADDR_WIDTH-1:0] reg_addr,
	input wire logic                  reg_wr,
	input wire logic [BANK_WIDTH-1:0] reg_wdata,
	input wire logic                  reg_rd,
	input wire logic [BANK_WIDTH-1:0] reg_rdata,
	input wire logic                  reg_rvalid,
	input wire logic                  irq_out_n_o,
	input wire logic                  irq_out_n_oe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////
	// Address decode helpers
	logic in_map;
	logic src_addr;
	assign in_map = reg_addr >= IRQ_SOURCE_HIGH_OFS
		&& reg_addr <= EDGE_EVENT_LOW_OFS;
	assign src_addr = reg_addr == IRQ_SOURCE_HIGH_OFS
		|| reg_addr == IRQ_SOURCE_LOW_OFS;
	// Clean read of a source register that shows a set bit
	sequence src_read_hit;
		reg_rd && !reg_wr && src_addr ##1 reg_rdata != STATUS_RESET;
	endsequence
	// Pins steady long enough that no edge can still be in flight
	sequence quiet_pins;
		(!irq_out_n_oe && $stable(pin_in)) [*6];
	endsequence
	////////////////////////////////////////
	// Register port and interrupt line relations
	a_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered next cycle");
	a_rvalid_needs_rd: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read valid without a read");
	a_unmapped_zero: assert property (
		reg_rd && !in_map |=> reg_rdata == STATUS_RESET)
		else $error("unmapped read not zero");
	a_line_level_low: assert property (irq_out_n_o == 1'b0)
		else $error("interrupt line level not low");
	a_source_holds_line: assert property (
		src_read_hit |-> irq_out_n_oe)
		else $error("source bit set but line released");
	a_release_by_clear: assert property (
		$fell(irq_out_n_oe) |-> $past(reg_wr) && $past(in_map)
		&& $past(reg_wdata) != STATUS_RESET)
		else $error("line released without a clear");
	a_zero_write_keeps: assert property (
		reg_wr && reg_wdata == STATUS_RESET && irq_out_n_oe
		|=> irq_out_n_oe)
		else $error("zero write released line");
	a_quiet_no_irq: assert property (quiet_pins |=> !irq_out_n_oe)
		else $error("interrupt without a pin edge");

endmodule : irq_status_monitor

bind gpio_event_interrupt_status irq_status_monitor i_irq_status_monitor (
	.ref_clk(ref_clk), .resetn(resetn), .pin_in(pin_in),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.irq_out_n_o(irq_out_n_o), .irq_out_n_oe(irq_out_n_oe));

// file: tb/host_model.sv
// Host side model: issues byte register accesses.
// Assumes one-cycle strobes sampled on the rising core clock edge.
`timescale 1ns/1ps

module host_model
	import irq_status_pkg::*;
(
	input  wire logic                  ref_clk,
	output logic      [ADDR_WIDTH-1:0] reg_addr,
	output logic                       reg_wr,
	output logic      [BANK_WIDTH-1:0] reg_wdata,
	output logic                       reg_rd,
	input  wire logic [BANK_WIDTH-1:0] reg_rdata,
	input  wire logic                  reg_rvalid
);
	// Idle port at time zero
	initial
	begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	////////////////////////////////////////
	// Write: data inverted after the strobe so stale bytes never match
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	// Read: answer taken one edge after the strobe is sampled
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge ref_clk);
		d = reg_rdata;
		v = reg_rvalid;
	endtask : rd

endmodule : host_model

// file: tb/gpio_event_interrupt_status_tb.sv
// Self-checking bench for the event and interrupt status block.
// Assumes the host model drives the register port; bench drives pins.
`timescale 1ns/1ps
`define check(nm, exp, got) begin checks_done++; if ((got) !== (exp)) \
	begin mismatches++; $display("wrong value %s exp %h got %h", nm, \
	exp, got); end end

module gpio_event_interrupt_status_tb import irq_status_pkg::*;;
	logic        ref_clk;
	logic        resetn;
	logic [15:0] pin_in;
	logic [31:0] edge_select_reg;
	logic [15:0] irq_enable_mask_reg;
	logic [7:0]  reg_addr;
	logic        reg_wr;
	logic [7:0]  reg_wdata;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        reg_rvalid;
	logic        irq_out_n_o;
	logic        irq_out_n_oe;
	logic        irq_line;
	int          mismatches = 0;
	int          checks_done = 0;
	// Pulled-up open-drain line
	assign irq_line = irq_out_n_oe ? irq_out_n_o : 1'b1;
	gpio_event_interrupt_status i_gpio_event_interrupt_status (
		.ref_clk(ref_clk), .resetn(resetn), .pin_in(pin_in),
		.edge_select_reg(edge_select_reg),
		.irq_enable_mask_reg(irq_enable_mask_reg),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.irq_out_n_o(irq_out_n_o), .irq_out_n_oe(irq_out_n_oe));
	host_model i_host_model (
		.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));
	////////////////////////////////////////
	// Read one register, judge data and the valid pulse
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       v;
		i_host_model.rd(a, d, v);
		`check("rvalid", 1'b1, v)
		`check($sformatf("reg %h", a), e, d)
	endtask : rchk
	// Toggle a pin and give the synchroniser time to land it
	task automatic toggle_pin(input int n);
		@(posedge ref_clk);
		pin_in[n] <= ~pin_in[n];
		repeat (6) @(posedge ref_clk);
	endtask : toggle_pin
	////////////////////////////////////////
	task automatic t_reset_values;
		rchk(8'h18, 8'h00);
		rchk(8'h19, 8'h00);
		rchk(8'h1a, 8'h00);
		rchk(8'h1b, 8'h00);
		rchk(8'h1c, 8'h00);
		`check("line", 1'b1, irq_line)
	endtask : t_reset_values
	// Pin 3 and 11 enabled, pin 10 masked; all on rising edges
	task automatic t_masked_events;
		@(posedge ref_clk);
		edge_select_reg <= 32'h0050_0040;
		irq_enable_mask_reg <= 16'h0808;
		toggle_pin(3);
		toggle_pin(10);
		toggle_pin(11);
		rchk(8'h1b, 8'h08);
		rchk(8'h19, 8'h08);
		rchk(8'h1a, 8'h0c);
		rchk(8'h18, 8'h08);
		`check("line", 1'b0, irq_line)
		i_host_model.wr(8'h1c, 8'hff);
		rchk(8'h19, 8'h08);
	endtask : t_masked_events
	// Zero writes ignored; line waits for both banks
	task automatic t_source_clear;
		i_host_model.wr(8'h19, 8'h00);
		rchk(8'h19, 8'h08);
		i_host_model.wr(8'h19, 8'h08);
		rchk(8'h1b, 8'h00);
		`check("line", 1'b0, irq_line)
		i_host_model.wr(8'h18, 8'h08);
		rchk(8'h1a, 8'h04);
		`check("line", 1'b1, irq_line)
	endtask : t_source_clear
	// Falling edge ignored on a rising pin, then event write clears
	task automatic t_event_clear;
		toggle_pin(3);
		rchk(8'h1b, 8'h00);
		toggle_pin(3);
		rchk(8'h19, 8'h08);
		`check("line", 1'b0, irq_line)
		i_host_model.wr(8'h1b, 8'h08);
		rchk(8'h19, 8'h00);
		rchk(8'h1b, 8'h00);
		`check("line", 1'b1, irq_line)
	endtask : t_event_clear
	task automatic t_select_change;
		@(posedge ref_clk);
		edge_select_reg[21:20] <= EDGE_BOTH;
		rchk(8'h1a, 8'h00);
	endtask : t_select_change
	// Every edge code on pin 0, masked, both directions
	task automatic t_edge_codes;
		logic [1:0] codes [4];
		logic       rise;
		logic       fall;
		codes = '{EDGE_NONE, EDGE_RISING, EDGE_FALLING, EDGE_BOTH};
		for (int i = 0; i < 4; i++)
		begin
			rise = codes[i] == EDGE_RISING || codes[i] == EDGE_BOTH;
			fall = codes[i] == EDGE_FALLING || codes[i] == EDGE_BOTH;
			@(posedge ref_clk);
			edge_select_reg[1:0] <= codes[i];
			toggle_pin(0);
			rchk(8'h1b, {7'h00, rise});
			i_host_model.wr(8'h1b, 8'h01);
			toggle_pin(0);
			rchk(8'h1b, {7'h00, fall});
			i_host_model.wr(8'h1b, 8'h01);
		end
	endtask : t_edge_codes
	// Reset mid-run with a source pending and pins 3, 10, 11 held high
	task automatic t_mid_reset;
		toggle_pin(3);
		toggle_pin(3);
		`check("line", 1'b0, irq_line)
		@(posedge ref_clk);
		resetn <= 1'b0;
		@(posedge ref_clk);
		`check("line", 1'b1, irq_line)
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rchk(8'h19, 8'h00);
		rchk(8'h1b, 8'h00);
		rchk(8'h18, 8'h00);
		rchk(8'h1a, 8'h00);
		`check("line", 1'b1, irq_line)
	endtask : t_mid_reset
	////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	// Core clock, 20 ns period
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Watchdog: the sequence needs well under 1000 cycles
	initial
	begin
		#100us;
		mismatches++;
		final_report();
	end
	// Main sequence; selection held at zero through reset
	initial
	begin
		resetn = 1'b0;
		pin_in = 16'h0000;
		edge_select_reg = 32'h0000_0000;
		irq_enable_mask_reg = 16'h0000;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		t_reset_values();
		t_masked_events();
		t_source_clear();
		t_event_clear();
		t_select_change();
		t_edge_codes();
		t_mid_reset();
		final_report();
	end

endmodule : gpio_event_interrupt_status_tb
